// >>> pbcs_pkg.sv
/*
 pbcs_pkg: constants and carrier types of the basic control and status
 register bank of a gigabit transceiver. Assumes a 4-bit AXI4-Lite byte
 address and 16-bit registers held in the low half of each data word.
*/
package pbcs_pkg;
   // register index and byte address
   localparam logic [3:0]  CTRL_IDX      = 4'h0;
   localparam logic [3:0]  STAT_IDX      = 4'h1;
   localparam logic [3:0]  CTRL_ADDR     = 4'(CTRL_IDX * 4);
   localparam logic [3:0]  STAT_ADDR     = 4'(STAT_IDX * 4);
   localparam logic [3:0]  IRQ_STAT_ADDR = 4'h8;
   localparam logic [3:0]  IRQ_MASK_ADDR = 4'hC;
   // control field positions
   localparam int          C_SOFT_RST    = 15;
   localparam int          C_LOOPBACK    = 14;
   localparam int          C_SPEED_LSB   = 13;
   localparam int          C_NEG_ON      = 12;
   localparam int          C_LOW_POWER   = 11;
   localparam int          C_ISOLATE     = 10;
   localparam int          C_RENEG       = 9;
   localparam int          C_FULL_DUP    = 8;
   localparam int          C_COL_TEST    = 7;
   localparam int          C_SPEED_MSB   = 6;
   // status field positions
   localparam int          S_NEG_DONE    = 5;
   localparam int          S_REM_FAULT   = 4;
   localparam int          S_LINK        = 2;
   localparam int          S_JABBER      = 1;
   // reset values and masks
   localparam logic [15:0] CTRL_RST      = 16'h1140;
   localparam logic [15:0] CTRL_WMASK    = 16'hF780;
   localparam logic [15:0] STAT_FIXED    = 16'h7949;
   // interrupt bit positions, own layout
   localparam int          I_REM_FAULT   = 0;
   localparam int          I_JABBER      = 1;
   localparam int          I_LINK_LOSS   = 2;
   localparam int          I_NEG_DONE    = 3;
   localparam int          I_RST_DONE    = 4;
   localparam int          IRQ_W         = 5;
   localparam logic [4:0]  IRQ_MASK_RST  = 5'h00;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // settings driven toward the transceiver machinery
   typedef struct packed {
      logic       softReset;
      logic       loopbackOn;
      logic [1:0] speedCode;
      logic       negotiationOn;
      logic       isolateOn;
      logic       renegotiateRequest;
      logic       fullDuplex;
      logic       collisionTestOn;
   } pbcs_ctrl_type;

   // state and events reported by the transceiver machinery
   typedef struct packed {
      logic resetDone;
      logic renegotiateAck;
      logic lowPowerState;
      logic negotiationDone;
      logic remoteFault;
      logic linkUp;
      logic jabberSeen;
   } pbcs_phy_type;
endpackage : pbcs_pkg

// >>> pbcs_regs.sv
/*
 pbcs_regs: control and status register bank with AXI4-Lite slave and
 one level interrupt. Assumes the transceiver machinery runs on clk,
 so its signals enter without synchronisers, and that it pulses
 resetDone and renegotiateAck for one cycle.
*/
// Functional notes
// - writing one to bit 15 starts soft reset; hardware clears it when done.
// - bit 14 loops MAC transmit data back to MAC receive.
// - forced speed code is bit 6 upper, bit 13 lower; 00/01/10 = 10/100/1000.
// - bit 12 enables auto-negotiation; resets to one.
// - bit 11 reports power-down state, read-only, resets to zero.
// - bit 10 isolates the MAC-side interface pins.
// - writing one to bit 9 restarts negotiation; hardware clears it.
// - bit 8 selects full duplex for forced mode; resets to one.
// - bit 7 enables collision signal test; resets to zero.
// - bit 6 is read-only and resets to one, giving 1000 Mb/s default.
// - status bits 14 to 11 read constant ones.
// - status bit 8 reads one, extended status present.
// - status bit 6 reads one, short preamble frames accepted.
// - status bit 5 follows negotiation completion; resets to zero.
// - status bit 4 sets on remote fault, cleared by status read.
// - status bit 3 reads one, negotiation capable.
// - status bit 2 latches low on link loss until read.
// - status bit 1 sets on jabber, cleared by status read.
`timescale 1ns/1ns
`default_nettype none
module pbcs_regs
   import pbcs_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic [3:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [3:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire pbcs_phy_type  phyState,
   output pbcs_ctrl_type      phyCtrl,
   output logic               irq
);
   logic [1:0]       rstSyncB_ff;
   logic             rstB;
   logic             awHeld_ff;
   logic             wHeld_ff;
   logic [3:0]       awAddr_ff;
   logic [15:0]      wData_ff;
   logic [1:0]       wStrb_ff;
   logic             bValid_ff;
   logic [1:0]       bResp_ff;
   logic             rValid_ff;
   logic [31:0]      rData_ff;
   logic [1:0]       rResp_ff;
   logic [3:0]       rdAddr_ff;
   logic             doWrite;
   logic             doRead;
   logic             rdStat;
   logic             rdIrq;
   logic [15:0]      ctrl_ff;
   logic [15:0]      statWord;
   logic             remFault_ff;
   logic             jabber_ff;
   logic             linkLatched_ff;
   logic             negDonePrev_ff;
   logic [IRQ_W-1:0] irqStat_ff;
   logic [IRQ_W-1:0] irqMask_ff;
   logic [IRQ_W-1:0] irqEvent;
   logic [15:0]      wMask;
   logic [15:0]      nxt_ctrl;
   logic [31:0]      nxt_rdata;
   logic [1:0]       nxt_rresp;

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSyncB_ff <= 2'b00;
      end else begin
         rstSyncB_ff <= {rstSyncB_ff[0], 1'b1};
      end
   end
   assign rstB = rstSyncB_ff[1];

   // write channel: address and data captured independently
   assign s_axi_awready = !awHeld_ff && !bValid_ff;
   assign s_axi_wready  = !wHeld_ff && !bValid_ff;
   assign doWrite       = awHeld_ff && wHeld_ff && !bValid_ff;

   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         awHeld_ff <= 1'b0;
         awAddr_ff <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_ff <= 1'b1;
         awAddr_ff <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         wHeld_ff <= 1'b0;
         wData_ff <= 16'h0000;
         wStrb_ff <= 2'b00;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_ff <= 1'b1;
         wData_ff <= s_axi_wdata[15:0];
         wStrb_ff <= s_axi_wstrb[1:0];
      end else if (doWrite) begin
         wHeld_ff <= 1'b0;
      end
   end

   // write response, held until the master takes it
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         bValid_ff <= 1'b0;
         bResp_ff  <= RESP_OKAY;
      end else if (doWrite) begin
         bValid_ff <= 1'b1;
         bResp_ff  <= (awAddr_ff == CTRL_ADDR || awAddr_ff == STAT_ADDR ||
                       awAddr_ff == IRQ_STAT_ADDR || awAddr_ff == IRQ_MASK_ADDR)
                      ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bValid_ff <= 1'b0;
      end
   end
   assign s_axi_bvalid = bValid_ff;
   assign s_axi_bresp  = bResp_ff;

   // byte lanes widened to a bit mask over the 16-bit register
   assign wMask = {{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};

   // control register; only writable bits take the write data
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (phyState.resetDone) begin
         nxt_ctrl = CTRL_RST;
      end
      if (phyState.renegotiateAck) begin
         nxt_ctrl[C_RENEG] = 1'b0;
      end
      if (doWrite && awAddr_ff == CTRL_ADDR) begin
         nxt_ctrl = (nxt_ctrl & ~(wMask & CTRL_WMASK)) |
                    (wData_ff & wMask & CTRL_WMASK);
         // self-clearing bits: a written zero never cancels a request
         nxt_ctrl[C_SOFT_RST] = nxt_ctrl[C_SOFT_RST] |
                                (ctrl_ff[C_SOFT_RST] & !phyState.resetDone);
         nxt_ctrl[C_RENEG]    = nxt_ctrl[C_RENEG] |
                                (ctrl_ff[C_RENEG] & !phyState.renegotiateAck);
      end
      nxt_ctrl[C_LOW_POWER] = 1'b0;
      nxt_ctrl[C_SPEED_MSB] = 1'b1;
      nxt_ctrl[5:0]         = 6'h00;
   end

   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         ctrl_ff <= CTRL_RST;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // settings driven to the machinery, all from flops
   assign phyCtrl.softReset          = ctrl_ff[C_SOFT_RST];
   assign phyCtrl.loopbackOn         = ctrl_ff[C_LOOPBACK];
   assign phyCtrl.speedCode          = {ctrl_ff[C_SPEED_MSB],
                                        ctrl_ff[C_SPEED_LSB]};
   assign phyCtrl.negotiationOn      = ctrl_ff[C_NEG_ON];
   assign phyCtrl.isolateOn          = ctrl_ff[C_ISOLATE];
   assign phyCtrl.renegotiateRequest = ctrl_ff[C_RENEG];
   assign phyCtrl.fullDuplex         = ctrl_ff[C_FULL_DUP];
   assign phyCtrl.collisionTestOn    = ctrl_ff[C_COL_TEST];

   // read channel, one read outstanding at a time
   assign s_axi_arready = !rValid_ff;
   assign doRead        = s_axi_arvalid && s_axi_arready;
   assign rdStat        = doRead && s_axi_araddr == STAT_ADDR;
   assign rdIrq         = doRead && s_axi_araddr == IRQ_STAT_ADDR;

   // status word; fixed ones plus live and latched bits
   always_comb begin
      statWord              = STAT_FIXED;
      statWord[S_NEG_DONE]  = phyState.negotiationDone;
      statWord[S_REM_FAULT] = remFault_ff;
      statWord[S_LINK]      = linkLatched_ff;
      statWord[S_JABBER]    = jabber_ff;
   end

   // read data mux; low-power bit is live, not stored
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
         CTRL_ADDR: begin
            nxt_rdata[15:0]        = ctrl_ff;
            nxt_rdata[C_LOW_POWER] = phyState.lowPowerState;
         end
         STAT_ADDR:     nxt_rdata[15:0]      = statWord;
         IRQ_STAT_ADDR: nxt_rdata[IRQ_W-1:0] = irqStat_ff;
         IRQ_MASK_ADDR: nxt_rdata[IRQ_W-1:0] = irqMask_ff;
         default:       nxt_rresp            = RESP_SLVERR;
      endcase
   end

   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         rValid_ff <= 1'b0;
         rData_ff  <= 32'h0000_0000;
         rResp_ff  <= RESP_OKAY;
         rdAddr_ff <= 4'h0;
      end else if (doRead) begin
         rValid_ff <= 1'b1;
         rData_ff  <= nxt_rdata;
         rResp_ff  <= nxt_rresp;
         rdAddr_ff <= s_axi_araddr;
      end else if (s_axi_rready) begin
         rValid_ff <= 1'b0;
      end
   end
   assign s_axi_rvalid = rValid_ff;
   assign s_axi_rdata  = rData_ff;
   assign s_axi_rresp  = rResp_ff;

   // sticky status bits; an event in the read cycle survives the read
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         remFault_ff <= 1'b0;
         jabber_ff   <= 1'b0;
      end else begin
         remFault_ff <= phyState.remoteFault | (remFault_ff & !rdStat);
         jabber_ff   <= phyState.jabberSeen | (jabber_ff & !rdStat);
      end
   end

   // link bit latches low; a read reloads the live level
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         linkLatched_ff <= 1'b0;
      end else if (!phyState.linkUp) begin
         linkLatched_ff <= 1'b0;
      end else if (rdStat) begin
         linkLatched_ff <= 1'b1;
      end
   end

   // interrupt events; negotiation done taken on its rising edge
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         negDonePrev_ff <= 1'b0;
      end else begin
         negDonePrev_ff <= phyState.negotiationDone;
      end
   end
   assign irqEvent[I_REM_FAULT] = phyState.remoteFault;
   assign irqEvent[I_JABBER]    = phyState.jabberSeen;
   assign irqEvent[I_LINK_LOSS] = !phyState.linkUp && linkLatched_ff;
   assign irqEvent[I_NEG_DONE]  = phyState.negotiationDone && !negDonePrev_ff;
   assign irqEvent[I_RST_DONE]  = phyState.resetDone;

   // interrupt status clears on read, set wins over the clear
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         irqStat_ff <= '0;
      end else begin
         irqStat_ff <= irqEvent | (irqStat_ff & {IRQ_W{!rdIrq}});
      end
   end

   // interrupt mask, one enables the bit onto irq
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         irqMask_ff <= IRQ_MASK_RST;
      end else if (doWrite && awAddr_ff == IRQ_MASK_ADDR && wStrb_ff[0]) begin
         irqMask_ff <= wData_ff[IRQ_W-1:0];
      end
   end
   assign irq = |(irqStat_ff & irqMask_ff);

   // checks on the design's own outputs and internal flops
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstB);

   a_soft_reset_done: assert property (
      phyState.resetDone && !doWrite |=> !phyCtrl.softReset && phyCtrl.negotiationOn)
      else $error("soft reset not cleared after completion");
   a_reneg_clear: assert property (
      phyState.renegotiateAck && !doWrite |=> !phyCtrl.renegotiateRequest)
      else $error("renegotiate request not cleared by ack");
   a_speed_msb_fixed: assert property (
      phyCtrl.speedCode[1] && !ctrl_ff[C_LOW_POWER])
      else $error("speed upper bit or power bit left its fixed value");
   a_power_mirror: assert property (
      doRead && s_axi_araddr == CTRL_ADDR |=>
      s_axi_rdata[C_LOW_POWER] == $past(phyState.lowPowerState))
      else $error("power-down bit does not follow machinery");
   a_fixed_caps: assert property (
      rValid_ff && rdAddr_ff == STAT_ADDR |->
      (s_axi_rdata & 32'h0000_7949) == 32'h0000_7949 && s_axi_rdata[31:15] == '0)
      else $error("fixed status abilities wrong");
   a_fault_sticky: assert property (
      phyState.remoteFault |=> remFault_ff [*1] ##1 (remFault_ff || $past(rdStat)))
      else $error("remote fault not held until read");
   a_link_latch: assert property (
      !phyState.linkUp |=> !linkLatched_ff)
      else $error("link loss not latched low");
   a_jabber_clear: assert property (
      rdStat && !phyState.jabberSeen |=> !jabber_ff)
      else $error("jabber bit not cleared by read");
   a_neg_done_live: assert property (
      doRead && s_axi_araddr == STAT_ADDR |=>
      s_axi_rdata[S_NEG_DONE] == $past(phyState.negotiationDone))
      else $error("negotiation done bit stale");
   a_rsvd_zero: assert property (
      rValid_ff && rdAddr_ff == CTRL_ADDR |-> s_axi_rdata[5:0] == 6'h00)
      else $error("reserved control bits not zero");
   a_write_answer: assert property (
      doWrite |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write response missing");
   // request bits: a written one reaches the machinery, completion drops it; loopback takes the written value
   a_soft_reset_set: assert property (
      doWrite && awAddr_ff == CTRL_ADDR && wStrb_ff[1] && wData_ff[C_SOFT_RST]
      |=> phyCtrl.softReset)
      else $error("soft reset request lost");
   a_soft_reset_drop: assert property (
      phyState.resetDone &&
      !(doWrite && awAddr_ff == CTRL_ADDR && wStrb_ff[1] && wData_ff[C_SOFT_RST])
      |=> !phyCtrl.softReset)
      else $error("soft reset held past completion");
   a_reneg_set: assert property (
      doWrite && awAddr_ff == CTRL_ADDR && wStrb_ff[1] && wData_ff[C_RENEG]
      |=> phyCtrl.renegotiateRequest)
      else $error("renegotiate request lost");
   a_loopback_write: assert property (
      doWrite && awAddr_ff == CTRL_ADDR && wStrb_ff[1] && !phyState.resetDone
      |=> phyCtrl.loopbackOn == $past(wData_ff[C_LOOPBACK]))
      else $error("loopback setting not taken");
   // status side: link reload, reserved zeros, writes ignored
   a_link_reload: assert property (
      rdStat && phyState.linkUp |=> linkLatched_ff)
      else $error("link latch not reloaded by read");
   a_stat_rsvd: assert property (
      rValid_ff && rdAddr_ff == STAT_ADDR |->
      !s_axi_rdata[15] && s_axi_rdata[10:9] == 2'b00 && !s_axi_rdata[7])
      else $error("reserved status bits not zero");
   a_stat_write_ignored: assert property (
      doWrite && awAddr_ff == STAT_ADDR && !phyState.resetDone && !phyState.renegotiateAck
      |=> ctrl_ff == $past(ctrl_ff))
      else $error("status write changed control");
   // read answers and read-to-clear of the interrupt status
   a_read_answer: assert property (
      doRead |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response missing");
   a_unmapped_error: assert property (
      doRead && s_axi_araddr != CTRL_ADDR && s_axi_araddr != STAT_ADDR &&
      s_axi_araddr != IRQ_STAT_ADDR && s_axi_araddr != IRQ_MASK_ADDR
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_irq_clear: assert property (
      rdIrq && irqEvent == '0 |=> irqStat_ff == '0)
      else $error("interrupt status not cleared by read");

   c_ctrl_write: cover property (doWrite && awAddr_ff == CTRL_ADDR ##1 bValid_ff);
   c_stat_read: cover property (rdStat && remFault_ff ##1 !remFault_ff);
   c_irq_fire: cover property (!irq ##1 irq);
   c_link_twice: cover property (rdStat ##[1:20] rdStat && linkLatched_ff);
endmodule : pbcs_regs
`default_nettype wire

// >>> pbcs_phy_model.sv
/*
 pbcs_phy_model: behavioural transceiver machinery facing the register bank.
 Assumes it shares clk and rst_b with the bank; the bench commands its events.
*/
`timescale 1ns/1ns
`default_nettype none
module pbcs_phy_model
   import pbcs_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire pbcs_ctrl_type phyCtrl,
   input  wire logic          linkCmd,
   input  wire logic          faultCmd,
   input  wire logic          jabberCmd,
   input  wire logic          lowPowerCmd,
   input  wire logic [7:0]    ackDelay,
   output pbcs_phy_type       phyState
);
   logic [7:0] waitCnt_ff;

   // levels follow the bench a cycle late; requests answered after ackDelay
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phyState   <= '0;
         waitCnt_ff <= 8'h00;
      end else begin
         phyState.resetDone      <= 1'b0;
         phyState.renegotiateAck <= 1'b0;
         phyState.lowPowerState  <= lowPowerCmd;
         phyState.linkUp         <= linkCmd;
         phyState.remoteFault    <= faultCmd;
         phyState.jabberSeen     <= jabberCmd;
         if (!(phyCtrl.softReset || phyCtrl.renegotiateRequest)) begin
            waitCnt_ff <= 8'h00;
         end else if (waitCnt_ff == ackDelay) begin
            // 8'hFF parks the counter until the bank drops its request
            waitCnt_ff               <= 8'hFF;
            phyState.resetDone       <= phyCtrl.softReset;
            phyState.renegotiateAck  <= !phyCtrl.softReset;
            phyState.negotiationDone <= !phyCtrl.softReset;
         end else if (waitCnt_ff != 8'hFF) begin
            waitCnt_ff               <= waitCnt_ff + 8'h01;
            phyState.negotiationDone <= 1'b0; // new negotiation under way
         end
      end
   end
endmodule : pbcs_phy_model
`default_nettype wire

// >>> phy_basic_control_status_regs_bench.sv
/*
 phy_basic_control_status_regs_bench: self-checking bench of pbcs_regs with
 the transceiver model; assumes the hand-over timing of the AXI4-Lite slave.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
   $display("[FAIL] %0t value %h expected %h", $time, got, exp); end end
module phy_basic_control_status_regs_bench import pbcs_pkg::*;;
   logic          clk, rst_b, irq, awvalid, awready, wvalid, wready, bvalid, bready;
   logic          arvalid, arready, rvalid, rready;
   logic          linkCmd, faultCmd, jabberCmd, lowPowerCmd;
   logic [3:0]    awaddr, araddr, wstrb, strb;
   logic [31:0]   wdata, rdata, rd;
   logic [1:0]    bresp, rresp, resp;
   logic [7:0]    ackDelay;
   logic [15:0]   d;
   pbcs_phy_type  phyState;
   pbcs_ctrl_type phyCtrl;
   int            err_total, checked, i, expLink, expFault, expJab, expNeg;

   pbcs_regs i_dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .phyState(phyState), .phyCtrl(phyCtrl), .irq(irq));
   pbcs_phy_model i_phy (.clk(clk), .rst_b(rst_b), .phyCtrl(phyCtrl), .linkCmd(linkCmd),
      .faultCmd(faultCmd), .jabberCmd(jabberCmd), .lowPowerCmd(lowPowerCmd),
      .ackDelay(ackDelay), .phyState(phyState));

   task automatic report_and_stop();
      if (err_total == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   // one write; an edge passes first so no signal is driven twice in a step
   task automatic axi_write(input logic [3:0] a, input logic [15:0] v);
      int   n;
      logic aw;
      logic w;
      n = 0;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk);
      awaddr <= a;
      wdata <= {16'h0000, v};
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end while (!bvalid && n < 200);
      resp = bresp;
      bready <= 1'b0;
      `CHK(bvalid, 1'b1)
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 200);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      `CHK(rvalid, 1'b1)
   endtask : axi_read

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      axi_read(a);
      `CHK(rd, {16'h0000, e})
      `CHK(resp, RESP_OKAY)
   endtask : rd_chk

   // the bench's status image; a read clears stickies and reloads the link latch
   task automatic stat_chk();
      rd_chk(STAT_ADDR, STAT_FIXED | 16'(expNeg << S_NEG_DONE) | 16'(expFault << S_REM_FAULT)
         | 16'(expLink << S_LINK) | 16'(expJab << S_JABBER));
      expFault = 0;
      expJab = 0;
      expLink = int'(linkCmd);
   endtask : stat_chk

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // hang guard, far above the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      report_and_stop();
   end

   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
      {linkCmd, faultCmd, jabberCmd, lowPowerCmd, awaddr, araddr, wstrb} = '0;
      {wdata, ackDelay, expLink, expFault, expJab, expNeg} = '0;
      strb = 4'hF;
      void'($urandom(1599));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(CTRL_ADDR, CTRL_RST);
      stat_chk();
      rd_chk(IRQ_STAT_ADDR, 16'h0000);
      rd_chk(IRQ_MASK_ADDR, 16'h0000);
      axi_read(4'h6);
      `CHK(resp, RESP_SLVERR)
      axi_write(4'h6, 16'hFFFF);
      `CHK(resp, RESP_SLVERR)
      axi_write(STAT_ADDR, 16'hFFFF);
      `CHK(resp, RESP_OKAY)
      stat_chk();
      // plain fields; request bits kept clear here, tested below
      for (i = 0; i < 8; i++) begin
         d = (i == 0) ? 16'h0000 : (i == 1) ? 16'h2000 : 16'($urandom);
         d = d & 16'h7DFF;
         lowPowerCmd <= i[0];
         axi_write(CTRL_ADDR, d);
         rd_chk(CTRL_ADDR, (d & 16'h7580) | 16'h0040 | {4'h0, i[0], 11'h000});
         `CHK(phyCtrl.loopbackOn, d[C_LOOPBACK])
         `CHK(phyCtrl.speedCode, {1'b1, d[C_SPEED_LSB]})
         `CHK(phyCtrl.negotiationOn, d[C_NEG_ON])
         `CHK(phyCtrl.isolateOn, d[C_ISOLATE])
         `CHK(phyCtrl.fullDuplex, d[C_FULL_DUP])
         `CHK(phyCtrl.collisionTestOn, d[C_COL_TEST])
      end
      lowPowerCmd <= 1'b0;
      // upper lane only: low byte keeps collision test and the fixed speed bit
      strb = 4'h2;
      axi_write(CTRL_ADDR, 16'h0000);
      strb = 4'hF;
      rd_chk(CTRL_ADDR, (d & 16'h0080) | 16'h0040);
      linkCmd <= 1'b1;
      // renegotiate slowly and promptly, then soft reset with loopback set
      for (i = 0; i < 3; i++) begin
         ackDelay <= (i == 1) ? 8'h01 : 8'h14;
         d = (i == 2) ? 16'hC000 : 16'h1340;
         axi_write(CTRL_ADDR, d);
         if (i != 1) begin
            `CHK(phyCtrl.softReset, d[C_SOFT_RST])
            `CHK(phyCtrl.renegotiateRequest, d[C_RENEG])
            rd_chk(CTRL_ADDR, (d & CTRL_WMASK) | 16'h0040);
         end
         repeat (30) @(posedge clk);
         expNeg = int'(d[C_RENEG]);
         rd_chk(CTRL_ADDR, CTRL_RST);
         stat_chk();
      end
      // sticky events and a short link loss
      faultCmd <= 1'b1;
      jabberCmd <= 1'b1;
      linkCmd <= 1'b0;
      @(posedge clk);
      faultCmd <= 1'b0;
      jabberCmd <= 1'b0;
      linkCmd <= 1'b1;
      repeat (3) @(posedge clk);
      expFault = 1;
      expJab = 1;
      expLink = 0;
      stat_chk();
      stat_chk();
      // interrupt: only remote fault unmasked
      rd_chk(IRQ_STAT_ADDR, 16'h001F);
      axi_write(IRQ_MASK_ADDR, 16'h0001);
      rd_chk(IRQ_MASK_ADDR, 16'h0001);
      jabberCmd <= 1'b1;
      @(posedge clk);
      jabberCmd <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      faultCmd <= 1'b1;
      @(posedge clk);
      faultCmd <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b1)
      rd_chk(IRQ_STAT_ADDR, 16'h0003);
      `CHK(irq, 1'b0)
      report_and_stop();
   end
endmodule : phy_basic_control_status_regs_bench
`default_nettype wire
